// ===== pio_port.sv
// General-purpose port with two bits wired to the internal serial memory

// Notes on behaviour
// - All pins but the input-only one work both ways; that one never drives.
// - Port reads return live pin levels; inputs are never latched.
// - Output latches keep their value until the port is written again.
// - Direction bit 0 drives the latch onto the pin, 1 makes it an input.
// - Bit set/clear reads pins, changes one bit, writes all latches back.
// - Writes update latches at cycle end; reads sample pins at cycle start.
// - Reset sets the top two bits; power-on clears pins, other resets keep them.
// - Bit 6 is serial data, bit 7 serial clock, reaching only the memory.
// - The serial memory holds sixteen bytes.
// - Data moving while the clock is high is a start or stop condition.
// - Idle bus has both lines high; a start is taken in any state, also mid-transfer.
// - One data bit per clock pulse, valid while the clock is high.
// - Direction register is write-only, loaded by instruction, set by every reset.
// - Pins given to an alternate function read as zero.
module pio_port #(
  parameter int MEM_BYTES = pio_pkg::MEM_BYTES
) (
  // Core clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       por_rst,
  // Link clock and reset of the serial memory
  input  wire logic       mem_clk,
  input  wire logic       mem_rst_n,
  // Register access from the CPU core
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] rd_data,
  // Bit set and bit clear instructions
  input  wire logic       bit_op,
  input  wire logic       bit_set,
  input  wire logic [2:0] bit_idx,
  // Direction and option load instructions
  input  wire logic       dir_load,
  input  wire logic [5:0] dir_wdata,
  input  wire logic       opt_load,
  input  wire logic [7:0] opt_wdata,
  // Configuration word
  input  wire logic [5:0] alt_func_mask,
  // Device pins
  input  wire logic [5:0] pin_in,
  output logic      [5:0] pin_out,
  output logic      [5:0] pin_oe,
  output logic      [5:0] pull_up_en,
  // Serial memory state
  output logic            mem_busy
);

  if (MEM_BYTES != pio_pkg::MEM_BYTES) begin : g_chk
    $error("the serial memory must hold sixteen bytes");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [5:0] pin_s1, pin_s2;
  logic       sda_low_s1, sda_low_s2, busy_s1, busy_s2;
  logic       mem_sda_pull, mem_bus_busy;
  logic [7:0] out_latch, next_out_latch;
  logic [5:0] dir, next_dir;
  logic [7:0] option, next_option;
  logic [7:0] next_rd_data;
  logic [5:0] next_pin_oe, next_pull_up_en;
  logic       port_sel;
  logic [7:0] read_val, rmw_val;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Memory-side flags are cleared in reset so the first read after release is defined
  always_ff @(posedge clk) begin
    pin_s1 <= pin_in;
    pin_s2 <= pin_s1;
    if (!rst_n) begin
      sda_low_s1 <= 1'b0;
      sda_low_s2 <= 1'b0;
      busy_s1    <= 1'b0;
      busy_s2    <= 1'b0;
    end else begin
      sda_low_s1 <= mem_sda_pull;
      sda_low_s2 <= sda_low_s1;
      busy_s1    <= mem_bus_busy;
      busy_s2    <= busy_s1;
    end
  end

  // ---------------------------------------------------------------
  // Port value as software sees it
  // ---------------------------------------------------------------
  assign port_sel = (reg_addr == pio_pkg::PORT_DATA_ADDR);

  always_comb begin
    read_val = {out_latch[pio_pkg::SCL_BIT],
                out_latch[pio_pkg::SDA_BIT] & ~sda_low_s2,
                pin_s2 & ~alt_func_mask};
    rmw_val  = read_val;
    rmw_val[bit_idx] = bit_set;
  end

  // ---------------------------------------------------------------
  // Next-state of latches, direction and option
  // ---------------------------------------------------------------
  always_comb begin
    next_out_latch = out_latch;
    next_dir       = dir;
    next_option    = option;
    next_rd_data   = rd_data;
    if (!rst_n) begin
      next_out_latch[7:6] = pio_pkg::MEM_LINES_RESET;
      if (por_rst) begin
        next_out_latch[5:0] = pio_pkg::PIN_POR_VALUE;
      end
      next_dir     = pio_pkg::DIR_RESET;
      next_option  = pio_pkg::OPT_RESET;
      next_rd_data = pio_pkg::RD_RESET;
    end else begin
      if (bit_op && port_sel) begin
        next_out_latch = rmw_val;
      end else if (reg_wr && port_sel) begin
        next_out_latch = reg_wdata;
      end
      if (dir_load) begin
        next_dir = dir_wdata;
      end
      if (opt_load) begin
        next_option = opt_wdata;
      end
      if (reg_rd && port_sel) begin
        next_rd_data = read_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_comb begin
    next_pin_oe = ~next_dir;
    next_pin_oe[pio_pkg::INPUT_ONLY] = 1'b0;
    if (next_option[pio_pkg::OPT_T0CS]) begin
      // Pin serves as the timer clock input
      next_pin_oe[pio_pkg::T0CKI_PIN] = 1'b0;
    end
    next_pull_up_en = next_option[pio_pkg::OPT_PU_N] ? 6'h00 : pio_pkg::PULL_UP_PINS;
  end

  always_ff @(posedge clk) begin
    out_latch  <= next_out_latch;
    dir        <= next_dir;
    option     <= next_option;
    rd_data    <= next_rd_data;
    pin_oe     <= next_pin_oe;
    pull_up_en <= next_pull_up_en;
    mem_busy   <= rst_n ? busy_s2 : 1'b0;
  end

  assign pin_out = out_latch[5:0];

  // ---------------------------------------------------------------
  // Serial memory on the link clock
  // ---------------------------------------------------------------
  pio_serial_mem #(
    .MEM_BYTES (MEM_BYTES)
  ) u_mem (
    .mem_clk      (mem_clk),
    .mem_rst_n    (mem_rst_n),
    .scl_in       (out_latch[pio_pkg::SCL_BIT]),
    .sda_in       (out_latch[pio_pkg::SDA_BIT]),
    .sda_pull_low (mem_sda_pull),
    .bus_busy     (mem_bus_busy)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_input_only_never_drives;
    @(posedge clk) disable iff (!rst_n)
      !pin_oe[pio_pkg::INPUT_ONLY];
  endproperty
  a_input_only_never_drives: assert property (p_input_only_never_drives)
    else $error("input-only pin driven");

  property p_read_live_pins;
    @(posedge clk) disable iff (!rst_n)
      reg_rd && port_sel |=> rd_data[5:0] == ($past(pin_s2) & ~$past(alt_func_mask));
  endproperty
  a_read_live_pins: assert property (p_read_live_pins)
    else $error("port read not from pins");

  property p_latch_holds;
    @(posedge clk) disable iff (!rst_n)
      !(port_sel && (reg_wr || bit_op)) |=> $stable(out_latch);
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("output latch changed without write");

  property p_direction_drives;
    @(posedge clk) disable iff (!rst_n)
      dir_load && !(opt_load ? opt_wdata[pio_pkg::OPT_T0CS] : option[pio_pkg::OPT_T0CS])
      |=> pin_oe[1:0] == ~$past(dir_wdata[1:0]) && pin_oe[5:4] == ~$past(dir_wdata[5:4]);
  endproperty
  a_direction_drives: assert property (p_direction_drives)
    else $error("pin enable does not follow direction");

  property p_bit_set_rmw;
    @(posedge clk) disable iff (!rst_n)
      bit_op && port_sel && bit_set && bit_idx == 3'h5
      |=> out_latch[5] && out_latch[4:0] == $past(read_val[4:0])
          && out_latch[7:6] == $past(read_val[7:6]);
  endproperty
  a_bit_set_rmw: assert property (p_bit_set_rmw)
    else $error("bit set did not write pins back");

  property p_write_at_cycle_end;
    @(posedge clk) disable iff (!rst_n)
      reg_wr && port_sel && !bit_op |=> out_latch == $past(reg_wdata) ##1 pin_out == $past(reg_wdata[5:0], 2) || reg_wr || bit_op;
  endproperty
  a_write_at_cycle_end: assert property (p_write_at_cycle_end)
    else $error("port write not taken");

  property p_reset_values;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> dir == pio_pkg::DIR_RESET && pin_oe == 6'h00
        && out_latch[7:6] == pio_pkg::MEM_LINES_RESET && rd_data == pio_pkg::RD_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values wrong");

  property p_reset_keeps_pins;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) && !$past(por_rst) |-> out_latch[5:0] == $past(out_latch[5:0]);
  endproperty
  a_reset_keeps_pins: assert property (p_reset_keeps_pins)
    else $error("warm reset lost pin latches");

  property p_alt_reads_zero;
    @(posedge clk) disable iff (!rst_n)
      reg_rd && port_sel && alt_func_mask[0] |=> !rd_data[0];
  endproperty
  a_alt_reads_zero: assert property (p_alt_reads_zero)
    else $error("alternate pin read nonzero");

  c_rmw: cover property (@(posedge clk) disable iff (!rst_n)
    bit_op && port_sel ##1 bit_op && port_sel);
  c_write_then_read: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && port_sel ##2 reg_rd && port_sel);
  c_mem_busy: cover property (@(posedge clk) disable iff (!rst_n) $rose(mem_busy));

endmodule

// ===== pio_pkg.sv
// Constants and types shared by the port block and its serial memory
package pio_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_ADDR     = 8'h03;
  localparam logic [7:0] PORT_DATA_ADDR = 8'h06;

  // ---------------------------------------------------------------
  // Port layout
  // ---------------------------------------------------------------
  localparam int PORT_W      = 8;
  localparam int PIN_W       = 6;
  localparam int INPUT_ONLY  = 3;
  localparam int T0CKI_PIN   = 2;
  localparam int SDA_BIT     = 6;
  localparam int SCL_BIT     = 7;
  localparam logic [5:0] PULL_UP_PINS = 6'h0b;

  // ---------------------------------------------------------------
  // Option field positions (OPT_T0CS active-high, OPT_PU_N and OPT_WU_N active-low)
  // ---------------------------------------------------------------
  localparam int OPT_T0CS = 5;
  localparam int OPT_PU_N = 6;
  localparam int OPT_WU_N = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [5:0] DIR_RESET       = 6'h3f;
  localparam logic [7:0] OPT_RESET       = 8'hff;
  localparam logic [1:0] MEM_LINES_RESET = 2'h3;
  localparam logic [5:0] PIN_POR_VALUE   = 6'h00;
  localparam logic [7:0] RD_RESET        = 8'h00;

  // ---------------------------------------------------------------
  // Serial memory
  // ---------------------------------------------------------------
  localparam int MEM_BYTES  = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic {PIO_LINK_IDLE, PIO_LINK_BUSY} pio_link_e;

endpackage

// ===== pio_serial_mem.sv
// Two-wire serial data memory running on its own clock
module pio_serial_mem #(
  parameter int MEM_BYTES = 16
) (
  // Link clock and reset
  input  wire logic mem_clk,
  input  wire logic mem_rst_n,
  // Lines from the port latch, other clock domain
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Memory side of the data line and bus state
  output logic      sda_pull_low,
  output logic      bus_busy
);

  localparam int AW = $clog2(MEM_BYTES);

  if (MEM_BYTES < 2 || (1 << AW) != MEM_BYTES) begin : g_chk
    $error("MEM_BYTES must be a power of two, at least 2");
  end

  // ---------------------------------------------------------------
  // Line synchronisers and edge detection
  // ---------------------------------------------------------------
  logic                 scl_s1, scl_s2, sda_s1, sda_s2, scl_d, sda_d;
  logic                 line_sda, start_cond, stop_cond, scl_rise, scl_fall;
  pio_pkg::pio_link_e   state, next_state;
  logic [3:0]           bit_cnt, next_bit_cnt;
  logic [1:0]           byte_cnt, next_byte_cnt;
  logic [7:0]           shift, next_shift, tx, next_tx;
  logic [AW-1:0]        ptr, next_ptr;
  logic                 rd_mode, next_rd_mode, next_pull;
  logic [7:0]           mem [MEM_BYTES];
  logic [7:0]           next_mem [MEM_BYTES];

  assign line_sda   = sda_s2 & ~sda_pull_low;
  assign start_cond = scl_s2 & scl_d & sda_d & ~line_sda;
  assign stop_cond  = scl_s2 & scl_d & ~sda_d & line_sda;
  assign scl_rise   = scl_s2 & ~scl_d;
  assign scl_fall   = ~scl_s2 & scl_d;
  assign bus_busy   = (state == pio_pkg::PIO_LINK_BUSY);

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_shift    = shift;
    next_tx       = tx;
    next_ptr      = ptr;
    next_rd_mode  = rd_mode;
    next_pull     = sda_pull_low;
    next_mem      = mem;
    if (start_cond) begin
      next_state    = pio_pkg::PIO_LINK_BUSY;
      next_bit_cnt  = 4'h0;
      next_byte_cnt = 2'h0;
      next_rd_mode  = 1'b0;
      next_pull     = 1'b0;
    end else if (stop_cond) begin
      next_state = pio_pkg::PIO_LINK_IDLE;
      next_pull  = 1'b0;
    end else if (state == pio_pkg::PIO_LINK_BUSY && scl_rise) begin
      if (bit_cnt == pio_pkg::BITS_PER_BYTE) begin
        next_bit_cnt = 4'h0;
        // Master left the acknowledge high: stop sending and free the data line
        if (rd_mode && byte_cnt != 2'h0 && line_sda) begin
          next_rd_mode = 1'b0;
        end
      end else begin
        next_shift   = {shift[6:0], line_sda};
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end else if (state == pio_pkg::PIO_LINK_BUSY && scl_fall) begin
      if (bit_cnt == pio_pkg::BITS_PER_BYTE) begin
        if (rd_mode && byte_cnt != 2'h0) begin
          // Master owns the acknowledge slot after a data byte
          next_pull = 1'b0;
          next_ptr  = ptr + AW'(1);
          next_tx   = mem[ptr + AW'(1)];
        end else begin
          next_pull = 1'b1;
          unique case (byte_cnt)
            2'h0: begin
              next_rd_mode = shift[0];
              next_tx      = mem[ptr];
            end
            2'h1:    next_ptr = shift[AW-1:0];
            default: begin
              next_mem[ptr] = shift;
              next_ptr      = ptr + AW'(1);
            end
          endcase
          if (byte_cnt != 2'h2) begin
            next_byte_cnt = byte_cnt + 2'h1;
          end
        end
      end else if (rd_mode && byte_cnt != 2'h0) begin
        next_pull = ~tx[3'(7 - int'(bit_cnt))];
      end else begin
        next_pull = 1'b0;
      end
    end
  end

  always_ff @(posedge mem_clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    if (!mem_rst_n) begin
      scl_d        <= 1'b1;
      sda_d        <= 1'b1;
      state        <= pio_pkg::PIO_LINK_IDLE;
      bit_cnt      <= 4'h0;
      byte_cnt     <= 2'h0;
      shift        <= 8'h00;
      tx           <= 8'h00;
      ptr          <= '0;
      rd_mode      <= 1'b0;
      sda_pull_low <= 1'b0;
    end else begin
      scl_d        <= scl_s2;
      sda_d        <= line_sda;
      state        <= next_state;
      bit_cnt      <= next_bit_cnt;
      byte_cnt     <= next_byte_cnt;
      shift        <= next_shift;
      tx           <= next_tx;
      ptr          <= next_ptr;
      rd_mode      <= next_rd_mode;
      sda_pull_low <= next_pull;
    end
    mem <= next_mem;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_start_restarts;
    @(posedge mem_clk) disable iff (!mem_rst_n)
      start_cond |=> bus_busy && bit_cnt == 4'h0 && byte_cnt == 2'h0;
  endproperty
  a_start_restarts: assert property (p_start_restarts) else $error("start not seen");

  property p_one_bit_per_pulse;
    @(posedge mem_clk) disable iff (!mem_rst_n)
      bus_busy && scl_rise && !start_cond && !stop_cond && bit_cnt < 4'h8
      |=> bit_cnt == $past(bit_cnt) + 4'h1;
  endproperty
  a_one_bit_per_pulse: assert property (p_one_bit_per_pulse) else $error("bit count slip");

  property p_stop_idles;
    @(posedge mem_clk) disable iff (!mem_rst_n)
      stop_cond && !start_cond |=> !bus_busy && !sda_pull_low;
  endproperty
  a_stop_idles: assert property (p_stop_idles) else $error("stop not honoured");

  c_write_byte: cover property (@(posedge mem_clk) disable iff (!mem_rst_n)
    bus_busy && byte_cnt == 2'h2 && scl_fall && bit_cnt == 4'h8);

endmodule

// ===== pio_pin_env.sv
// Pin environment model: external drivers, weak pull-ups and floating pins
module pio_pin_env (
  // Clock
  input  wire logic       clk,
  // Port side
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pull_up_en,
  // External drivers set by the test
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_val,
  // Levels seen at the pins
  output logic      [5:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] float_pat = 6'h2a;
  // Floating pins toggle every cycle so a stale level never reads back
  always @(posedge clk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_pat[i];
    end
  end
endmodule

// ===== tb.sv
// Self-checking bench for the port block and its serial memory
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PA = pio_pkg::PORT_DATA_ADDR;
  localparam int HALF = 48;
  localparam int LIMIT = 30000;
  logic clk = 1'b0, rst_n = 1'b0, por_rst = 1'b1, mem_clk = 1'b0, mem_rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, opt_wdata = 8'h00, rd_data, d;
  logic reg_rd = 1'b0, reg_wr = 1'b0, bit_op = 1'b0, bit_set = 1'b0;
  logic dir_load = 1'b0, opt_load = 1'b0, mem_busy;
  logic [2:0] bit_idx = 3'h0;
  logic [5:0] dir_wdata = 6'h00, alt_func_mask = 6'h00, pin_in, pin_out, pin_oe, pull_up_en;
  logic [5:0] ext_en = 6'h3f, ext_val = 6'h15;
  int mismatches = 0, tests_run = 0, cycles = 0;

  always #5 clk = ~clk;
  initial begin
    #7;
    forever #32 mem_clk = ~mem_clk;
  end

  pio_port dut_u (.clk(clk), .rst_n(rst_n), .por_rst(por_rst), .mem_clk(mem_clk),
    .mem_rst_n(mem_rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .rd_data(rd_data), .bit_op(bit_op), .bit_set(bit_set),
    .bit_idx(bit_idx), .dir_load(dir_load), .dir_wdata(dir_wdata), .opt_load(opt_load),
    .opt_wdata(opt_wdata), .alt_func_mask(alt_func_mask), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .mem_busy(mem_busy));

  pio_pin_env env_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = rd_data;
  endtask

  task automatic bit_cmd(input logic [7:0] a, input logic s, input logic [2:0] i);
    @(negedge clk);
    reg_addr = a;
    bit_set = s;
    bit_idx = i;
    bit_op = 1'b1;
    @(negedge clk);
    bit_op = 1'b0;
  endtask

  task automatic load(input logic [5:0] dv, input logic [7:0] ov);
    @(negedge clk);
    dir_wdata = dv;
    opt_wdata = ov;
    dir_load = 1'b1;
    opt_load = 1'b1;
    @(negedge clk);
    dir_load = 1'b0;
    opt_load = 1'b0;
    cyc(1);
  endtask

  // Serial lines are driven only through port writes, top bits of the latch
  task automatic line(input logic scl, input logic sda);
    reg_write(PA, {scl, sda, 6'h00});
    cyc(HALF);
  endtask

  task automatic clk_bit(input logic b, output logic r);
    logic [7:0] v;
    line(1'b0, b);
    line(1'b1, b);
    reg_read(PA, v);
    r = v[6];
    line(1'b0, b);
  endtask

  task automatic send_byte(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], r);
    clk_bit(1'b1, r);
    check("mem_ack", {7'h00, r}, 8'h00);
  endtask

  task automatic recv_byte(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      v[i] = r;
    end
    clk_bit(1'b1, r);
  endtask

  task automatic start_cond();
    line(1'b1, 1'b1);
    line(1'b1, 1'b0);
    check("busy_start", {7'h00, mem_busy}, 8'h01);
    line(1'b0, 1'b0);
  endtask

  task automatic stop_cond();
    line(1'b0, 1'b0);
    line(1'b1, 1'b0);
    line(1'b1, 1'b1);
    check("busy_stop", {7'h00, mem_busy}, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(4);
    rst_n = 1'b1;
    mem_rst_n = 1'b1;
    check("oe_por", {2'h0, pin_oe}, 8'h00);
    check("out_por", {2'h0, pin_out}, 8'h00);
    check("pull_por", {2'h0, pull_up_en}, 8'h00);
    reg_read(PA, d);
    check("read_por", d, 8'hd5);
    ext_val = 6'h2a;
    cyc(3);
    reg_read(PA, d);
    check("read_live", d, 8'hea);
    reg_write(pio_pkg::FLAGS_ADDR, 8'h00);
    check("out_other", {2'h0, pin_out}, 8'h00);
    reg_write(PA, 8'he5);
    check("out_wr", {2'h0, pin_out}, 8'h25);
    load(6'h00, 8'hff);
    check("oe_all", {2'h0, pin_oe}, 8'h33);
    load(6'h00, 8'h9f);
    check("oe_opt", {2'h0, pin_oe}, 8'h37);
    check("pull_on", {2'h0, pull_up_en}, 8'h0b);
    ext_en = 6'h08;
    cyc(3);
    reg_read(PA, d);
    check("read_drv", d, 8'hed);
    alt_func_mask = 6'h01;
    cyc(1);
    reg_read(PA, d);
    check("read_alt", d, 8'hec);
    alt_func_mask = 6'h00;
    load(6'h38, 8'h9f);
    ext_en = 6'h38;
    ext_val = 6'h38;
    cyc(3);
    bit_cmd(PA, 1'b0, 3'h4);
    check("rmw_clr", {2'h0, pin_out}, 8'h2d);
    bit_cmd(PA, 1'b1, 3'h1);
    check("rmw_set", {2'h0, pin_out}, 8'h3f);
    bit_cmd(pio_pkg::FLAGS_ADDR, 1'b0, 3'h0);
    check("rmw_other", {2'h0, pin_out}, 8'h3f);
    load(6'h00, 8'h9f);
    ext_en = 6'h08;
    cyc(3);
    reg_addr = PA;
    reg_wdata = 8'hc0;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check("read_stale", rd_data, 8'hff);
    cyc(3);
    reg_read(PA, d);
    check("read_new", d, 8'hc8);
    start_cond();
    send_byte(8'ha0);
    send_byte(8'h05);
    send_byte(8'ha7);
    stop_cond();
    start_cond();
    send_byte(8'ha0);
    send_byte(8'h15);
    start_cond();
    send_byte(8'ha1);
    recv_byte(d);
    check("mem_data", d, 8'ha7);
    stop_cond();
    reg_write(PA, 8'hd6);
    @(negedge clk);
    rst_n = 1'b0;
    por_rst = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    check("out_keep", {2'h0, pin_out}, 8'h16);
    check("oe_ext", {2'h0, pin_oe}, 8'h00);
    ext_en = 6'h3f;
    ext_val = 6'h11;
    cyc(3);
    reg_read(PA, d);
    check("read_ext", d, 8'hd1);
    close_out();
  end
endmodule
